/* File: hw/fcsu_top.sv */
// command port, write engine and engine_status_reg of the flash command and status unit
//
// Notes on behaviour
// RULE_01 - identifier mode: address zero gives maker code, address one device code.
// RULE_02 - identifier address five returns the read configuration value.
// RULE_03 - identifier and status modes serve single reads only, no page or burst.
// RULE_04 - identifier mode lasts until another valid command is written.
// RULE_05 - identifier, status read and clear commands ignore the supply level.
// RULE_06 - status read command accepted any time; reads then give status. Code: not as the second write of an erase, program or read config setup.
// RULE_07 - status latched on address valid rise, sync clock edge, or strobe fall.
// RULE_08 - four error flags set by engine only, kept until clear command. Code: a bad erase confirm also sets both error flags from the command port.
// RULE_09 - clear command clears error flags and returns to array mode.
// RULE_10 - erase is setup write then confirm inside the target block.
// RULE_11 - completed erase leaves every word of the block all ones.
// RULE_12 - engine preconditions, erases and verifies the block on its own.
// RULE_13 - after the erase sequence reads return status until next command.
// RULE_14 - host polls ready bit then inspects the error bits.
// RULE_15 - host should clear status after an error before new commands.
// RULE_16 - status bit map: ready, suspends, errors, supply, lock, reserved.
// RULE_17 - program suspend halts program and sets ready and program halt flag.
// RULE_18 - locked block with write protect low aborts and sets lock flag. Code: with the supply also low it sets the supply flag instead.
// RULE_19 - after reset: array mode, status ready with no flags.
// RULE_20 - host holds write protect high for commands to lockable blocks.
// RULE_21 - erase suspend sets ready and erase suspend flag until resume.
// RULE_22 - host masks the reserved status bit zero.
// RULE_23 - error and supply bits only meaningful while ready reads one.
`timescale 1ns/10ps
`default_nettype none
module fcsu_top
   import fcsu_pkg::*;
(
   input wire logic clk, // 40 MHz system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic ce_n_pin, // chip select, active low
   input wire logic oe_n_pin, // output enable, active low
   input wire logic we_n_pin, // write strobe, active low
   input wire logic address_valid_n, // address valid, active low
   input wire logic burst_clk, // burst clock pin, sampled
   input wire logic [ADDR_W-1:0] addr_pin, // address pins
   input wire logic [DATA_W-1:0] dq_in, // data pins, input side
   output logic [DATA_W-1:0] dq_out, // data pins, output side
   output logic dq_oe, // data pins driven when high
   input wire logic wp_n, // write protect, active low
   input wire logic vpp_ok, // programming supply above lockout
   input wire logic [NBLK-1:0] locked_blocks // lock state per block
);
   // ==========================================================
   // pin synchronisers
   logic [PIN_W-1:0] raw;
   logic [PIN_W-1:0] s1_r, s2_r, s3_r, filt_r, prev_r;
   fcsu_pins_t cur, prv;
   assign raw = {burst_clk, address_valid_n, we_n_pin, oe_n_pin, ce_n_pin, wp_n, vpp_ok,
                 dq_in, addr_pin};
   assign cur = filt_r;
   assign prv = prev_r;

   // three stages; a bit counts only once stages two and three agree
   for (genvar i = 0; i < PIN_W; i++) begin : g_sync
      always_ff @(posedge clk) begin
         if (rst) begin
            s1_r[i] <= PINS_RST[i];
            s2_r[i] <= PINS_RST[i];
            s3_r[i] <= PINS_RST[i];
            filt_r[i] <= PINS_RST[i];
            prev_r[i] <= PINS_RST[i];
         end else begin
            s1_r[i] <= raw[i];
            s2_r[i] <= s1_r[i];
            s3_r[i] <= s2_r[i];
            if (s2_r[i] == s3_r[i]) begin
               filt_r[i] <= s3_r[i];
            end
            prev_r[i] <= filt_r[i];
         end
      end
   end

   // ==========================================================
   // bus events
   logic wr_end, adv_rise, bclk_rise, oe_fall, ce_fall, rd_ev;
   logic [DATA_W-1:0] rcfg_r;
   logic [7:0] cmd;
   // command data is taken from the cycle before the strobe rose
   assign wr_end = ~(prv.we_n | prv.ce_n) & (cur.we_n | cur.ce_n);
   assign cmd = prv.dq[7:0];
   assign adv_rise = ~prv.adv_n & cur.adv_n;
   assign bclk_rise = ~prv.bclk & cur.bclk & ~cur.adv_n & rcfg_r[RCFG_SYNC];
   assign oe_fall = prv.oe_n & ~cur.oe_n;
   assign ce_fall = prv.ce_n & ~cur.ce_n;
   assign rd_ev = adv_rise | bclk_rise | oe_fall | ce_fall; // [RULE_07]

   // ==========================================================
   // command port
   fcsu_mode_t mode_r, mode_nxt;
   fcsu_eng_t eng_r;
   logic halt_r, busy, ready;
   logic start_erase, start_prog, clr_cmd, susp_cmd, resume_cmd, rcfg_wr, seq_err;
   logic is_prog;
   assign busy = (eng_r != E_IDLE) & ~halt_r;
   assign ready = (eng_r == E_IDLE) | halt_r;
   assign is_prog = (cmd == CMD_PROG) | (cmd == CMD_PROG_ALT);

   // no command is gated by the supply level; only the engine looks at it
   always_comb begin
      mode_nxt = mode_r;
      start_erase = 1'b0;
      start_prog = 1'b0;
      clr_cmd = 1'b0;
      susp_cmd = 1'b0;
      resume_cmd = 1'b0;
      rcfg_wr = 1'b0;
      seq_err = 1'b0;
      if (wr_end) begin
         case (mode_r)
            M_ESETUP: begin
               mode_nxt = M_STATUS; // [RULE_13]
               if (cmd == CMD_CONFIRM) begin
                  start_erase = 1'b1; // [RULE_10]
               end else begin
                  seq_err = 1'b1;
               end
            end
            M_PSETUP: begin
               mode_nxt = M_STATUS;
               start_prog = 1'b1;
            end
            M_RSETUP: begin
               mode_nxt = M_ARRAY;
               rcfg_wr = (cmd == CMD_RCFG_OK);
            end
            default: begin
               if (cmd == CMD_STATUS) begin
                  mode_nxt = M_STATUS; // [RULE_06] [RULE_05]
               end else if (busy) begin
                  // array reads are refused while the engine runs
                  if (cmd == CMD_SUSPEND) begin
                     susp_cmd = 1'b1;
                     mode_nxt = M_STATUS;
                  end
               end else if (halt_r) begin
                  if (cmd == CMD_READ_ARRAY) begin
                     mode_nxt = M_ARRAY;
                  end else if (cmd == CMD_CONFIRM) begin
                     resume_cmd = 1'b1;
                     mode_nxt = M_STATUS;
                  end
               end else if (cmd == CMD_READ_ARRAY) begin
                  mode_nxt = M_ARRAY; // [RULE_04]
               end else if (cmd == CMD_IDENT) begin
                  mode_nxt = M_IDENT; // [RULE_05]
               end else if (cmd == CMD_CLEAR) begin
                  clr_cmd = 1'b1; // [RULE_05]
                  mode_nxt = M_ARRAY; // [RULE_09]
               end else if (cmd == CMD_ERASE) begin
                  mode_nxt = M_ESETUP;
               end else if (is_prog) begin
                  mode_nxt = M_PSETUP;
               end else if (cmd == CMD_RCFG) begin
                  mode_nxt = M_RSETUP;
               end
            end
         endcase
      end
   end

   // mode and read configuration
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_r <= M_ARRAY; // [RULE_19]
         rcfg_r <= RCFG_RST;
      end else begin
         mode_r <= mode_nxt;
         if (rcfg_wr) begin
            rcfg_r <= prv.addr[DATA_W-1:0];
         end
      end
   end

   // ==========================================================
   // write engine and array
   logic [DATA_W-1:0] mem [0:(1<<ARR_AW)-1];
   logic [BLK_W-1:0] blk_r, tgt_blk;
   logic [WIDX_W-1:0] widx_r;
   logic [3:0] tmr_r;
   logic [ARR_AW-1:0] paddr_r, mem_wa;
   logic [DATA_W-1:0] pdata_r, mem_wd, mem_cur;
   logic is_erase_r, ess_r, pss_r;
   logic e_err_r, p_err_r, v_low_r, lock_r;
   logic op_vlow, op_lock, op_go, step, last_w, mem_we, verr, perr;
   assign tgt_blk = prv.addr[ARR_AW-1:WIDX_W];
   assign op_vlow = ~prv.vpp_ok;
   assign op_lock = locked_blocks[tgt_blk] & ~prv.wp_n; // [RULE_18]
   assign op_go = (start_erase | start_prog) & ~op_vlow & ~op_lock;
   assign step = busy & (tmr_r == 4'h0); // [RULE_12]
   assign last_w = (widx_r == WIDX_LAST);
   assign mem_wa = (eng_r == E_PROG) ? paddr_r : {blk_r, widx_r};
   assign mem_cur = mem[mem_wa];
   assign mem_we = step & (eng_r != E_VERIFY);
   assign mem_wd = (eng_r == E_PROG) ? (mem_cur & pdata_r) :
                   (eng_r == E_ERASE) ? ERASED_WORD : ZERO_WORD; // [RULE_11]
   assign verr = step & (eng_r == E_VERIFY) & (mem_cur != ERASED_WORD);
   assign perr = step & (eng_r == E_PROG) & (mem_wd != pdata_r);

   // array store; contents survive reset
   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   // engine sequence: erase runs precondition, erase, verify; program is one step; one word per step
   always_ff @(posedge clk) begin
      if (rst) begin
         eng_r <= E_IDLE;
         blk_r <= '0;
         widx_r <= '0;
         tmr_r <= 4'h0;
         paddr_r <= '0;
         pdata_r <= ZERO_WORD;
         is_erase_r <= 1'b0;
      end else if (op_go) begin
         eng_r <= start_erase ? E_PRECOND : E_PROG; // [RULE_12]
         blk_r <= tgt_blk; // [RULE_10]
         widx_r <= '0;
         tmr_r <= STEP_CYC - 4'h1;
         paddr_r <= prv.addr[ARR_AW-1:0];
         pdata_r <= prv.dq;
         is_erase_r <= start_erase;
      end else if (step) begin
         tmr_r <= STEP_CYC - 4'h1;
         widx_r <= widx_r + 4'h1;
         case (eng_r)
            E_PRECOND: eng_r <= last_w ? E_ERASE : E_PRECOND;
            E_ERASE: eng_r <= last_w ? E_VERIFY : E_ERASE;
            E_VERIFY: eng_r <= last_w ? E_IDLE : E_VERIFY;
            default: eng_r <= E_IDLE;
         endcase
      end else if (busy) begin
         tmr_r <= tmr_r - 4'h1;
      end
   end

   // suspend halts the engine at once; resume lets the timer run on
   always_ff @(posedge clk) begin
      if (rst) begin
         halt_r <= 1'b0;
         ess_r <= 1'b0;
         pss_r <= 1'b0;
      end else if (susp_cmd) begin
         halt_r <= 1'b1;
         ess_r <= is_erase_r; // [RULE_21]
         pss_r <= ~is_erase_r; // [RULE_17]
      end else if (resume_cmd) begin
         halt_r <= 1'b0;
         ess_r <= 1'b0;
         pss_r <= 1'b0;
      end
   end

   // sticky error flags; a set in the clear cycle wins
   always_ff @(posedge clk) begin
      if (rst) begin
         e_err_r <= 1'b0;
         p_err_r <= 1'b0;
         v_low_r <= 1'b0;
         lock_r <= 1'b0;
      end else begin
         e_err_r <= (e_err_r & ~clr_cmd) | verr | seq_err |
                    (start_erase & (op_vlow | op_lock)); // [RULE_08]
         p_err_r <= (p_err_r & ~clr_cmd) | perr | seq_err |
                    (start_prog & (op_vlow | op_lock)); // [RULE_08]
         v_low_r <= (v_low_r & ~clr_cmd) | ((start_erase | start_prog) & op_vlow);
         lock_r <= (lock_r & ~clr_cmd) |
                   ((start_erase | start_prog) & ~op_vlow & op_lock); // [RULE_18]
      end
   end

   // ==========================================================
   // engine_status_reg; error bits are settled only while ready
   logic [7:0] status_now;
   assign status_now[SR_READY] = ready; // [RULE_16] [RULE_23]
   assign status_now[SR_ESUSP] = ess_r;
   assign status_now[SR_EERR] = e_err_r;
   assign status_now[SR_PERR] = p_err_r;
   assign status_now[SR_VLOW] = v_low_r;
   assign status_now[SR_PSUSP] = pss_r;
   assign status_now[SR_LOCK] = lock_r;
   assign status_now[SR_RSVD] = 1'b0;

   // ==========================================================
   // read path; identifier and status words change only on a read event
   logic [DATA_W-1:0] id_word, dq_r;
   logic dq_oe_r;
   assign id_word = (cur.addr == ID_MAKER) ? MAKER_CODE : // [RULE_01]
                    (cur.addr == ID_DEVICE) ? DEVICE_CODE :
                    (cur.addr == ID_RCFG) ? rcfg_r : ZERO_WORD; // [RULE_02]

   always_ff @(posedge clk) begin
      if (rst) begin
         dq_r <= ZERO_WORD;
         dq_oe_r <= 1'b0;
      end else begin
         dq_oe_r <= ~cur.ce_n & ~cur.oe_n & cur.we_n;
         if (mode_r == M_IDENT) begin
            dq_r <= rd_ev ? id_word : dq_r; // [RULE_03]
         end else if (mode_r == M_ARRAY) begin
            dq_r <= mem[cur.addr[ARR_AW-1:0]];
         end else begin
            dq_r <= rd_ev ? {8'h00, status_now} : dq_r; // [RULE_03] [RULE_07]
         end
      end
   end
   assign dq_out = dq_r;
   assign dq_oe = dq_oe_r;

   // ==========================================================
   // checks
   chk_ident_maker: assert property (@(posedge clk) disable iff (rst) // [RULE_01]
      (mode_r == M_IDENT && rd_ev && cur.addr == ID_MAKER) |=> dq_out == MAKER_CODE)
      else $error("maker code not returned");
   chk_ident_rcfg: assert property (@(posedge clk) disable iff (rst) // [RULE_02]
      (mode_r == M_IDENT && rd_ev && cur.addr == ID_RCFG) |=> dq_out == $past(rcfg_r))
      else $error("configuration value not returned");
   chk_single_read: assert property (@(posedge clk) disable iff (rst) // [RULE_03]
      (mode_r == M_STATUS && !rd_ev) |=> $stable(dq_out))
      else $error("status output moved without a read event");
   chk_status_latch: assert property (@(posedge clk) disable iff (rst) // [RULE_07]
      (mode_r == M_STATUS && rd_ev) |=> dq_out == {8'h00, $past(status_now)})
      else $error("status not latched on read event");
   chk_flag_sticky: assert property (@(posedge clk) disable iff (rst) // [RULE_08]
      (e_err_r && !clr_cmd) |=> e_err_r)
      else $error("erase error flag dropped without clear");
   chk_clear_mode: assert property (@(posedge clk) disable iff (rst) // [RULE_09]
      clr_cmd |=> (mode_r == M_ARRAY && status_now[SR_EERR:SR_LOCK] == 5'h00))
      else $error("clear command did not clear flags");
   chk_erase_ones: assert property (@(posedge clk) disable iff (rst) // [RULE_11]
      (mem_we && eng_r == E_ERASE) |-> mem_wd == ERASED_WORD)
      else $error("erase wrote a word other than all ones");
   chk_erase_auto: assert property (@(posedge clk) disable iff (rst) // [RULE_12]
      (op_go && start_erase && !susp_cmd) ##1 !halt_r [*8] |-> eng_r == E_PRECOND)
      else $error("erase did not run on its own");
   chk_erase_status: assert property (@(posedge clk) disable iff (rst) // [RULE_13]
      start_erase |=> mode_r == M_STATUS)
      else $error("erase sequence did not enter status mode");
   chk_lock_abort: assert property (@(posedge clk) disable iff (rst) // [RULE_18]
      ((start_erase || start_prog) && !op_vlow && op_lock) |=>
         (lock_r && eng_r == E_IDLE && ready))
      else $error("locked block not aborted");
   chk_suspend_flags: assert property (@(posedge clk) disable iff (rst) // [RULE_17] [RULE_21]
      susp_cmd |=> (status_now[SR_READY] && (is_erase_r ? status_now[SR_ESUSP] :
         status_now[SR_PSUSP])))
      else $error("suspend flags not set");
   chk_reset_state: assert property (@(posedge clk) // [RULE_19]
      rst |=> (mode_r == M_ARRAY && status_now == SR_RST))
      else $error("reset state wrong");
endmodule
`default_nettype wire

/* File: hw/fcsu_pkg.sv */
// constants, types and field layout of the flash command and status unit
package fcsu_pkg;
   // ==========================================================
   // bus widths and array geometry
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int BLK_W = 3;
   localparam int WIDX_W = 4;
   localparam int ARR_AW = BLK_W + WIDX_W;
   localparam int NBLK = 8;
   localparam logic [WIDX_W-1:0] WIDX_LAST = 4'hF;
   // ==========================================================
   // command codes
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR = 8'h50;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_PROG = 8'h40;
   localparam logic [7:0] CMD_PROG_ALT = 8'h10;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_RCFG = 8'h60;
   localparam logic [7:0] CMD_RCFG_OK = 8'h03;
   // ==========================================================
   // identifier space, values arbitrary for the two codes
   localparam logic [ADDR_W-1:0] ID_MAKER = 20'h0_0000;
   localparam logic [ADDR_W-1:0] ID_DEVICE = 20'h0_0001;
   localparam logic [ADDR_W-1:0] ID_RCFG = 20'h0_0005;
   localparam logic [DATA_W-1:0] MAKER_CODE = 16'h00A5; // arbitrary value
   localparam logic [DATA_W-1:0] DEVICE_CODE = 16'h5A01; // arbitrary value
   localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
   localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
   localparam logic [DATA_W-1:0] RCFG_RST = 16'h0000;
   localparam int RCFG_SYNC = 15;
   // ==========================================================
   // engine_status_reg layout
   localparam int SR_READY = 7;
   localparam int SR_ESUSP = 6;
   localparam int SR_EERR = 5;
   localparam int SR_PERR = 4;
   localparam int SR_VLOW = 3;
   localparam int SR_PSUSP = 2;
   localparam int SR_LOCK = 1;
   localparam int SR_RSVD = 0;
   localparam logic [7:0] SR_RST = 8'h80;
   // ==========================================================
   // engine timing: cycles spent on each word of a step
   localparam logic [3:0] STEP_CYC = 4'h4;
   // ==========================================================
   // synchronised pins, field order equals the raw vector
   typedef struct packed {
      logic bclk;
      logic adv_n;
      logic we_n;
      logic oe_n;
      logic ce_n;
      logic wp_n;
      logic vpp_ok;
      logic [DATA_W-1:0] dq;
      logic [ADDR_W-1:0] addr;
   } fcsu_pins_t;
   localparam int PIN_W = $bits(fcsu_pins_t);
   localparam logic [PIN_W-1:0] PINS_RST = {7'h3E, ZERO_WORD, 20'h0_0000};
   // ==========================================================
   // command port modes and write engine states
   typedef enum logic [5:0] {
      M_ARRAY = 6'h01, M_IDENT = 6'h02, M_STATUS = 6'h04,
      M_ESETUP = 6'h08, M_PSETUP = 6'h10, M_RSETUP = 6'h20
   } fcsu_mode_t;
   typedef enum logic [4:0] {
      E_IDLE = 5'h01, E_PRECOND = 5'h02, E_ERASE = 5'h04,
      E_VERIFY = 5'h08, E_PROG = 5'h10
   } fcsu_eng_t;
endpackage

/* File: verif/fcsu_host.sv */
// host bus master model for the flash command and status unit
`timescale 1ns/10ps
`default_nettype none
module fcsu_host
   import fcsu_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic [DATA_W-1:0] dq_out, // device read data
   output logic ce_n, // chip select, active low
   output logic oe_n, // output enable, active low
   output logic we_n, // write strobe, active low
   output logic adv_n, // address valid, active low
   output logic [ADDR_W-1:0] addr, // address pins
   output logic [DATA_W-1:0] dq_in // write data pins
);
   // ==========================================================
   // idle bus at time zero
   initial begin
      ce_n = 1'b1;
      oe_n = 1'b1;
      we_n = 1'b1;
      adv_n = 1'b1;
      addr = 20'h0_0000;
      dq_in = 16'h0000;
   end

   // ==========================================================
   // bus cycles
   // strobes held 6 clk each way, beyond the 3-flop pin filter
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge clk);
      addr = a;
      dq_in = d;
      ce_n = 1'b0;
      adv_n = 1'b0;
      we_n = 1'b0;
      repeat (6) @(negedge clk);
      we_n = 1'b1;
      ce_n = 1'b1;
      adv_n = 1'b1;
      repeat (6) @(negedge clk);
      dq_in = ~d; // released bus: no stale data left on the pins
   endtask

   // single read only; the oe and ce falls form one read event
   task automatic rd(input logic [ADDR_W-1:0] a, input int hold,
                     output logic [DATA_W-1:0] d);
      @(negedge clk);
      addr = a;
      ce_n = 1'b0;
      adv_n = 1'b0;
      oe_n = 1'b0;
      repeat (hold) @(negedge clk);
      d = dq_out;
      oe_n = 1'b1;
      ce_n = 1'b1;
      adv_n = 1'b1;
      repeat (6) @(negedge clk);
   endtask

   // poll ready, then hand back status with the reserved bit masked
   task automatic poll(output logic [7:0] sr);
      logic [DATA_W-1:0] d;
      d = 16'h0000;
      for (int i = 0; i < 60 && d[SR_READY] !== 1'b1; i++) begin
         rd(20'h0_0000, 8, d);
      end
      sr = d[7:0] & 8'hFE;
   endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking testbench of the flash command and status unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import fcsu_pkg::*;
   localparam logic [7:0] M_EERR = 8'(1 << SR_EERR);
   localparam logic [7:0] M_VLOW = 8'(1 << SR_VLOW);
   localparam logic [7:0] M_LOCK = 8'(1 << SR_LOCK);
   localparam logic [7:0] M_ESUSP = 8'(1 << SR_ESUSP);
   localparam logic [7:0] M_PERR = 8'(1 << SR_PERR);
   logic clk = 1'b0;
   logic bclk = 1'b0;
   logic rst = 1'b1;
   logic wp_n = 1'b1;
   logic vpp_ok = 1'b1;
   logic [NBLK-1:0] locked_blocks = 8'h00;
   logic ce_n, oe_n, we_n, adv_n, dq_oe;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] dq_in, dq_out, d;
   logic [7:0] sr;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;

   fcsu_top uut (.clk(clk), .rst(rst), .ce_n_pin(ce_n), .oe_n_pin(oe_n), .we_n_pin(we_n),
      .address_valid_n(adv_n), .burst_clk(bclk), .addr_pin(addr), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .wp_n(wp_n), .vpp_ok(vpp_ok),
      .locked_blocks(locked_blocks));
   fcsu_host host (.clk(clk), .dq_out(dq_out), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .adv_n(adv_n), .addr(addr), .dq_in(dq_in));

   // ==========================================================
   // clock and hang guard
   always #12.5 clk = ~clk;
   // whole run needs well under 10k clk; the ceiling leaves slack
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         conclude();
      end
   end

   // ==========================================================
   // helpers
   function automatic logic [ADDR_W-1:0] wa(input int b, input int w);
      return ADDR_W'(b * 16 + w);
   endfunction
   function automatic logic [DATA_W-1:0] cw(input logic [7:0] c);
      return {8'h00, c};
   endfunction
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                        input string what);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic erase_blk(input int b);
      host.wr(wa(0, 0), cw(CMD_ERASE));
      host.wr(wa(b, 3), cw(CMD_CONFIRM));
      host.poll(sr);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      host.wr(wa(0, 0), cw(CMD_STATUS));
      host.rd(wa(0, 0), 8, d);
      check(d, cw(SR_RST), "status after reset");
   endtask

   // identifier reads with the supply below lockout
   task automatic t_ident;
      vpp_ok = 1'b0;
      host.wr(wa(1, 2), cw(CMD_IDENT));
      host.rd(ID_MAKER, 8, d);
      check(d, MAKER_CODE, "maker code");
      host.rd(ID_DEVICE, 8, d);
      check(d, DEVICE_CODE, "device code");
      host.rd(ID_RCFG, 8, d);
      check(d, RCFG_RST, "read config");
      host.rd(ID_MAKER, 8, d);
      check(d, MAKER_CODE, "ident persists");
      vpp_ok = 1'b1;
   endtask

   // erase one block, the neighbour must keep its programmed word
   task automatic t_erase;
      erase_blk(3);
      erase_blk(2);
      host.wr(wa(0, 0), cw(CMD_PROG));
      host.wr(wa(3, 5), 16'h1234);
      host.poll(sr);
      check(cw(sr), cw(SR_RST), "program ok");
      host.wr(wa(0, 0), cw(CMD_ERASE));
      host.wr(wa(2, 7), cw(CMD_CONFIRM));
      // long hold: status must stay latched from the oe fall
      host.rd(wa(2, 7), 250, d);
      check(d & cw(8'h80), 16'h0000, "busy latched");
      host.poll(sr);
      check(cw(sr), cw(SR_RST), "erase done");
      host.wr(wa(0, 0), cw(CMD_READ_ARRAY));
      for (int w = 0; w < 16; w++) begin
         host.rd(wa(2, w), 8, d);
         check(d, ERASED_WORD, "erased word");
      end
      host.rd(wa(3, 5), 8, d);
      check(d, 16'h1234, "other block kept");
   endtask

   // errors accumulate, then clear returns to array mode
   task automatic t_errors;
      vpp_ok = 1'b0;
      erase_blk(4);
      check(cw(sr), cw(SR_RST | M_EERR | M_VLOW), "supply abort");
      vpp_ok = 1'b1;
      locked_blocks = 8'h02;
      wp_n = 1'b0;
      erase_blk(1);
      check(cw(sr), cw(SR_RST | M_EERR | M_VLOW | M_LOCK), "lock abort");
      wp_n = 1'b1;
      locked_blocks = 8'h00;
      vpp_ok = 1'b0;
      host.wr(wa(0, 0), cw(CMD_CLEAR));
      host.rd(wa(2, 0), 8, d);
      check(d, ERASED_WORD, "array after clear");
      host.wr(wa(0, 0), cw(CMD_STATUS));
      host.rd(wa(0, 0), 8, d);
      check(d, cw(SR_RST), "flags cleared");
      vpp_ok = 1'b1;
   endtask

   // suspend mid-erase, status command while suspended, resume
   task automatic t_suspend;
      host.wr(wa(0, 0), cw(CMD_ERASE));
      host.wr(wa(5, 0), cw(CMD_CONFIRM));
      host.wr(wa(0, 0), cw(CMD_SUSPEND));
      host.rd(wa(0, 0), 8, d);
      check(d, cw(SR_RST | M_ESUSP), "suspended");
      host.wr(wa(0, 0), cw(CMD_STATUS));
      host.rd(wa(0, 0), 8, d);
      check(d, cw(SR_RST | M_ESUSP), "still suspended");
      host.wr(wa(5, 0), cw(CMD_CONFIRM));
      host.poll(sr);
      check(cw(sr), cw(SR_RST), "resumed done");
   endtask

   // sync configuration: a burst clock edge late in a held read replaces the latched busy status with ready
   task automatic t_rcfg;
      host.wr(20'h0_8000, cw(CMD_RCFG));
      host.wr(20'h0_8000, cw(CMD_RCFG_OK));
      host.wr(wa(0, 0), cw(CMD_IDENT));
      host.rd(ID_RCFG, 8, d);
      check(d, 16'h8000, "read config set");
      host.wr(wa(0, 0), cw(CMD_ERASE));
      host.wr(wa(6, 0), cw(CMD_CONFIRM));
      fork
         host.rd(wa(0, 0), 300, d);
         begin
            repeat (100) @(negedge clk);
            check(16'(dq_oe), 16'h0001, "bus driven");
            repeat (160) @(negedge clk);
            bclk = 1'b1;
         end
      join
      bclk = 1'b0;
      check(d, cw(SR_RST), "burst edge refresh");
      check(16'(dq_oe), 16'h0000, "bus released");
      host.wr(wa(0, 0), cw(CMD_ERASE));
      host.wr(wa(6, 0), cw(CMD_READ_ARRAY));
      host.poll(sr);
      check(cw(sr), cw(SR_RST | M_EERR | M_PERR), "bad confirm");
   endtask

   // ==========================================================
   // verdict and main sequence
   task automatic conclude;
      if (err_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      t_reset();
      t_ident();
      t_erase();
      t_errors();
      t_suspend();
      t_rcfg();
      conclude();
   end
endmodule
`default_nettype wire
